// ===== acc_ctrl.sv
// Configuration, calibration sequencing and filter selection for a multiplexed converter.
//
// The address map and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
// What the document requires
// R1: Modulator clock is the master clock divided by 128, or 256 with speed bit set.
// R2: Self calibration: offset or gain take 7 periods, both together take 14.
// R3: System offset needs zero input, system gain full-scale input; each takes 7 periods.
// R4: Host keeps the current range field zero throughout any calibration.
// R5: Host writes a new offset shift only after calibration completes.
// R6: Data ready output goes low when calibration completes.
// R7: Host should calibrate after power-on and after each gain change.
// R8: Filter selectable as fast settling, sinc2, sinc3 or automatic.
// R9: Auto mode after channel or gain change: two fast (first discarded), sinc2, sinc3.
// R10: All mux select bits one connects the temperature diode, current one biasing anode; the code does not force current one on.
// R11: Any input positive and any other negative, up to eight differential pairs.
// R12: Burnout bit enables sourcing current on positive, sinking on negative input.
// R13: Input buffer enabled only when buffer pin and buffer bit are both high.
// R14: Two current sources, each 8-bit code scaled by two to the range minus one.
// R15: Gain setting chooses 1, 2, 4, 8, 16, 32, 64 or 128.
// R16: Offset shift code is sign-magnitude, top bit sign, seven bits magnitude.
// R17: Reference powers up internal 2.5V; selectable internal or external, 1.25V or 2.5V.
// R18: All eight I/O pins come up as inputs, each direction configurable.
// R19: Direction per pin; level register drives outputs and reads input pins.
// R20: Channel selects: 0-7 inputs, other top-bit codes common input, 1111 diode.
module acc_ctrl
	import acc_pkg::*;
#(
	parameter logic [15:0] MOD_CYCLES_PER_CONV = 16'h0040
) (
	// Clock and reset.
	input  wire logic        core_clk,
	input  wire logic        reset_n,
	// Avalon-MM register slave.
	input  wire logic [7:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	// External pins.
	input  wire logic        buffer_pin,
	input  wire logic [7:0]  io_in,
	output logic      [7:0]  io_out,
	output logic      [7:0]  io_oe_n,
	output logic             mod_clk_out,
	output logic             result_valid_n,
	// Analog front end controls.
	output logic      [7:0]  ain_pos_en,
	output logic      [7:0]  ain_neg_en,
	output logic             common_pos_en,
	output logic             common_neg_en,
	output logic             temp_diode_en,
	output logic             burnout_source_en,
	output logic             burnout_sink_en,
	output logic             input_buffer_en,
	output logic      [10:0] excitation_one_scaled,
	output logic      [10:0] excitation_two_scaled,
	output logic      [7:0]  gain_factor,
	output logic             offset_negative,
	output logic      [6:0]  offset_magnitude,
	output logic             ref_internal_en,
	output logic             ref_high,
	// Conversion sequencing.
	output logic      [1:0]  filter_active,
	output logic             result_discard,
	output logic      [2:0]  cal_kind
);

	// Current source scaling: zero range is off, else code times two to range minus one.
	function automatic logic [10:0] exc_scale(input logic [7:0] code, input logic [1:0] range);
		logic [10:0] wide;
		wide = {3'h0, code};
		case (range)
			2'h1: exc_scale = wide;
			2'h2: exc_scale = wide << 1;
			2'h3: exc_scale = wide << 2;
			default: exc_scale = 11'h000;
		endcase
	endfunction

	logic [7:0]  setup_reg;
	logic [7:0]  mux_reg;
	logic [7:0]  analog_control_settings_reg;
	logic [7:0]  excitation_current_one_reg;
	logic [7:0]  excitation_current_two_reg;
	logic [7:0]  input_offset_shift_reg;
	logic [7:0]  io_pin_levels_reg;
	logic [7:0]  io_dir_reg;
	logic [1:0]  filter_mode_reg;
	logic        wait_reg;
	logic [31:0] rdata_reg;
	logic [1:0]  buf_sync_reg;
	logic [7:0]  io_meta_reg;
	logic [7:0]  io_sync_reg;
	logic [7:0]  mod_div_reg;
	logic        mod_clk_reg;
	logic [15:0] conv_cnt_reg;
	acc_state_e  state_reg;
	acc_cal_e    cal_kind_reg;
	logic [3:0]  cal_left_reg;
	logic        ready_n_reg;
	logic [1:0]  auto_stage_reg;
	logic        restart_reg;
	logic [1:0]  filt_out_reg;
	logic        discard_reg;

	logic        wr_take;
	logic        rd_take;
	logic        mod_tick;
	logic        conv_tick;
	logic        seq_change;
	logic [3:0]  psel;
	logic [3:0]  negative_input_select;
	logic        diode;
	logic [7:0]  io_read;
	logic [1:0]  filt_now;
	logic [2:0]  cal_cmd;
	logic        cal_start;

	assign wr_take  = avs_write && !wait_reg;
	assign rd_take  = avs_read && wait_reg;
	assign psel     = mux_reg[7:4];
	assign negative_input_select     = mux_reg[3:0];
	assign diode    = (psel == SEL_TEMP_DIODE) && (negative_input_select == SEL_TEMP_DIODE);
	assign cal_cmd  = avs_writedata[2:0];
	assign cal_start = wr_take && (avs_address == ADDR_CAL_CMD) && (state_reg == ACC_ST_IDLE)
		&& (cal_cmd >= 3'(ACC_CAL_SELF_OFS)) && (cal_cmd <= 3'(ACC_CAL_SYS_GAIN));
	// A channel change or a gain change restarts the automatic filter sequence.
	assign seq_change = wr_take && (((avs_address == ADDR_MUX) && (avs_writedata[7:0] != mux_reg))
		|| ((avs_address == ADDR_ANALOG)
		&& (avs_writedata[2:0] != analog_control_settings_reg[2:0])));
	// Input pins read back their own level, output pins the driven level.
	assign io_read  = (io_dir_reg & io_sync_reg) | (~io_dir_reg & io_pin_levels_reg); // [R19]
	assign filt_now = (filter_mode_reg != 2'(ACC_FILT_AUTO)) ? filter_mode_reg :
		(auto_stage_reg < 2'h2) ? 2'(ACC_FILT_FAST) :
		(auto_stage_reg == 2'h2) ? 2'(ACC_FILT_SINC2) : 2'(ACC_FILT_SINC3); // [R8] [R9]

	// Bus handshake: waitrequest drops for one cycle, one cycle after a request appears.
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			wait_reg <= 1'b1;
		end else if (wait_reg) begin
			wait_reg <= !(avs_read || avs_write);
		end else begin
			wait_reg <= 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			rdata_reg <= 32'h0000_0000;
		end else if (rd_take) begin
			case (avs_address)
				ADDR_SETUP:   rdata_reg <= {24'h000000, setup_reg};
				ADDR_MUX:     rdata_reg <= {24'h000000, mux_reg};
				ADDR_ANALOG:  rdata_reg <= {24'h000000, analog_control_settings_reg};
				ADDR_EXC_ONE: rdata_reg <= {24'h000000, excitation_current_one_reg};
				ADDR_EXC_TWO: rdata_reg <= {24'h000000, excitation_current_two_reg};
				ADDR_OFFSET:  rdata_reg <= {24'h000000, input_offset_shift_reg};
				ADDR_IO_LVL:  rdata_reg <= {24'h000000, io_read};
				ADDR_IO_DIR:  rdata_reg <= {24'h000000, io_dir_reg};
				ADDR_CAL_CMD: rdata_reg <= {29'h00000000, cal_kind_reg};
				ADDR_FILTER:  rdata_reg <= {30'h00000000, filter_mode_reg};
				ADDR_STATUS:  rdata_reg <= {27'h0000000, auto_stage_reg == 2'h0, filt_now,
					ready_n_reg, state_reg == ACC_ST_CAL};
				default:      rdata_reg <= 32'h0000_0000;
			endcase
		end
	end

	// Configuration registers written by software.
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			setup_reg                   <= SETUP_RST; // [R17]
			mux_reg                     <= MUX_RST;
			analog_control_settings_reg <= ANALOG_RST;
			excitation_current_one_reg  <= ZERO_RST;
			excitation_current_two_reg  <= ZERO_RST;
			input_offset_shift_reg      <= ZERO_RST;
			io_pin_levels_reg           <= ZERO_RST;
			io_dir_reg                  <= IO_DIR_RST; // [R18]
			filter_mode_reg             <= 2'(ACC_FILT_AUTO);
		end else if (wr_take) begin
			case (avs_address)
				ADDR_SETUP:   setup_reg <= avs_writedata[7:0];
				ADDR_MUX:     mux_reg <= avs_writedata[7:0]; // [R11] [R20]
				ADDR_ANALOG:  analog_control_settings_reg <= avs_writedata[7:0];
				ADDR_EXC_ONE: excitation_current_one_reg <= avs_writedata[7:0];
				ADDR_EXC_TWO: excitation_current_two_reg <= avs_writedata[7:0];
				ADDR_OFFSET:  input_offset_shift_reg <= avs_writedata[7:0];
				ADDR_IO_LVL:  io_pin_levels_reg <= avs_writedata[7:0];
				ADDR_IO_DIR:  io_dir_reg <= avs_writedata[7:0];
				ADDR_FILTER:  filter_mode_reg <= avs_writedata[1:0];
				default:      io_dir_reg <= io_dir_reg;
			endcase
		end
	end

	// Pin synchronisers.
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			buf_sync_reg <= 2'h0;
			io_meta_reg  <= 8'h00;
			io_sync_reg  <= 8'h00;
		end else begin
			buf_sync_reg <= {buf_sync_reg[0], buffer_pin};
			io_meta_reg  <= io_in;
			io_sync_reg  <= io_meta_reg;
		end
	end

	// Modulator clock: high phase is half the divide ratio less one cycle; a restart realigns the divider.
	assign mod_tick = setup_reg[SETUP_SPEED_BIT] ? (mod_div_reg == MOD_DIV_SLOW_LAST)
		: (mod_div_reg == MOD_DIV_FAST_LAST); // [R1]

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			mod_div_reg <= 8'h00;
			mod_clk_reg <= 1'b0;
		end else begin
			mod_div_reg <= (mod_tick || restart_reg) ? 8'h00 : mod_div_reg + 8'h01; // [R1]
			mod_clk_reg <= (mod_div_reg >= (setup_reg[SETUP_SPEED_BIT] ? 8'h80 : 8'h40))
				&& !mod_tick;
		end
	end

	// Conversion counter restarts with the divider, so the first period after a change is whole.
	assign conv_tick = mod_tick && !restart_reg && (conv_cnt_reg == MOD_CYCLES_PER_CONV - 16'h0001);

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			conv_cnt_reg <= 16'h0000;
			restart_reg  <= 1'b0;
		end else begin
			restart_reg <= seq_change || cal_start;
			if (restart_reg || conv_tick) begin
				conv_cnt_reg <= 16'h0000;
			end else if (mod_tick) begin
				conv_cnt_reg <= conv_cnt_reg + 16'h0001;
			end
		end
	end

	// Calibration sequencer.
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg    <= ACC_ST_IDLE;
			cal_kind_reg <= ACC_CAL_NONE;
			cal_left_reg <= 4'h0;
		end else begin
			case (state_reg)
				ACC_ST_IDLE: begin
					if (cal_start) begin
						state_reg    <= ACC_ST_CAL;
						cal_kind_reg <= acc_cal_e'(cal_cmd);
						cal_left_reg <= (cal_cmd == 3'(ACC_CAL_SELF_BOTH)) ?
							CAL_DOUBLE_PERIODS : CAL_SINGLE_PERIODS; // [R2] [R3]
					end
				end
				ACC_ST_CAL: begin
					if (conv_tick) begin
						cal_left_reg <= cal_left_reg - 4'h1;
						if (cal_left_reg == 4'h1) begin
							state_reg    <= ACC_ST_IDLE;
							cal_kind_reg <= ACC_CAL_NONE;
						end
					end
				end
				default: state_reg <= ACC_ST_IDLE;
			endcase
		end
	end

	// Data ready: high while calibrating or discarding, low when a valid result is ready.
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			ready_n_reg <= 1'b1;
		end else if (cal_start || seq_change) begin
			ready_n_reg <= 1'b1;
		end else if (conv_tick && (state_reg == ACC_ST_CAL) && (cal_left_reg == 4'h1)) begin
			ready_n_reg <= 1'b0; // [R6]
		end else if (conv_tick && (state_reg == ACC_ST_IDLE)) begin
			ready_n_reg <= (filter_mode_reg == 2'(ACC_FILT_AUTO)) && (auto_stage_reg == 2'h0);
		end
	end

	// Automatic filter stage advances once per finished conversion.
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			auto_stage_reg <= 2'h0;
		end else if (seq_change) begin
			auto_stage_reg <= 2'h0; // [R9]
		end else if (conv_tick && (state_reg == ACC_ST_IDLE)
			&& (auto_stage_reg != AUTO_LAST_STAGE)) begin
			auto_stage_reg <= auto_stage_reg + 2'h1; // [R9]
		end
	end

	// Registered outputs.
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			ain_pos_en            <= 8'h00;
			ain_neg_en            <= 8'h00;
			common_pos_en         <= 1'b0;
			common_neg_en         <= 1'b0;
			temp_diode_en         <= 1'b0;
			burnout_source_en     <= 1'b0;
			burnout_sink_en       <= 1'b0;
			input_buffer_en       <= 1'b0;
			excitation_one_scaled <= 11'h000;
			excitation_two_scaled <= 11'h000;
			gain_factor           <= 8'h01;
			offset_negative       <= 1'b0;
			offset_magnitude      <= 7'h00;
			ref_internal_en       <= 1'b1;
			ref_high              <= 1'b1;
			io_out                <= 8'h00;
			io_oe_n               <= 8'hFF;
		end else begin
			ain_pos_en        <= (!diode && !psel[3]) ? (8'h01 << psel[2:0]) : 8'h00; // [R11] [R20]
			ain_neg_en        <= (!diode && !negative_input_select[3]) ? (8'h01 << negative_input_select[2:0]) : 8'h00; // [R11] [R20]
			common_pos_en     <= !diode && psel[3]; // [R20]
			common_neg_en     <= !diode && negative_input_select[3]; // [R20]
			temp_diode_en     <= diode; // [R10]
			burnout_source_en <= analog_control_settings_reg[ANALOG_BURNOUT_BIT]; // [R12]
			burnout_sink_en   <= analog_control_settings_reg[ANALOG_BURNOUT_BIT]; // [R12]
			input_buffer_en   <= buf_sync_reg[1] && setup_reg[SETUP_BUF_EN_BIT]; // [R13]
			// The first current source follows its own code and range in diode mode too; nothing forces it on.
			excitation_one_scaled <= exc_scale(excitation_current_one_reg,
				analog_control_settings_reg[ANALOG_R1_LSB +: 2]); // [R14] [R10]
			excitation_two_scaled <= exc_scale(excitation_current_two_reg,
				analog_control_settings_reg[ANALOG_R2_LSB +: 2]); // [R14]
			gain_factor       <= 8'h01 << analog_control_settings_reg[2:0]; // [R15]
			offset_negative   <= input_offset_shift_reg[7]; // [R16]
			offset_magnitude  <= input_offset_shift_reg[6:0]; // [R16]
			ref_internal_en   <= setup_reg[SETUP_REF_EN_BIT]; // [R17]
			ref_high          <= setup_reg[SETUP_REF_HI_BIT]; // [R17]
			io_out            <= io_pin_levels_reg; // [R19]
			io_oe_n           <= io_dir_reg; // [R18] [R19]
		end
	end

	assign avs_readdata    = rdata_reg;
	assign avs_waitrequest = wait_reg;
	assign mod_clk_out     = mod_clk_reg;
	assign result_valid_n  = ready_n_reg;
	assign filter_active   = filt_out_reg;
	assign result_discard  = discard_reg;
	assign cal_kind        = cal_kind_reg;

	// Filter choice and discard flag registered for the outputs.
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			filt_out_reg   <= 2'(ACC_FILT_FAST);
			discard_reg    <= 1'b1;
		end else begin
			filt_out_reg   <= filt_now; // [R8]
			discard_reg    <= (filter_mode_reg == 2'(ACC_FILT_AUTO)) && (auto_stage_reg == 2'h0);
		end
	end

endmodule

// ===== acc_ctrl_properties.sv
// Port-level checker for the converter control block.
`timescale 1ns/100ps
module acc_ctrl_props #(
	parameter logic [15:0] MOD_CYCLES_PER_CONV = 16'h0040
) (
	// Clock and reset.
	input wire logic       core_clk,
	input wire logic       reset_n,
	// Watched ports.
	input wire logic       buffer_pin,
	input wire logic       result_valid_n,
	input wire logic [7:0] ain_pos_en,
	input wire logic [7:0] ain_neg_en,
	input wire logic       common_pos_en,
	input wire logic       common_neg_en,
	input wire logic       temp_diode_en,
	input wire logic       burnout_source_en,
	input wire logic       burnout_sink_en,
	input wire logic       input_buffer_en,
	input wire logic [7:0] gain_factor,
	input wire logic [1:0] filter_active,
	input wire logic       result_discard,
	input wire logic [2:0] cal_kind
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	a_diode_alone: assert property (temp_diode_en |->
		ain_pos_en == 8'h00 && ain_neg_en == 8'h00 && !common_pos_en && !common_neg_en)
		else $error("Diode selected together with a channel.");
	a_pos_select: assert property ($onehot0({ain_pos_en, common_pos_en, temp_diode_en}))
		else $error("More than one positive source selected.");
	a_neg_select: assert property ($onehot0({ain_neg_en, common_neg_en, temp_diode_en}))
		else $error("More than one negative source selected.");
	a_burnout_pair: assert property (burnout_source_en == burnout_sink_en)
		else $error("Burnout source and sink disagree.");
	a_gain_single: assert property ($onehot(gain_factor))
		else $error("Gain factor is not a single power of two.");
	a_buffer_pin: assert property (!buffer_pin [*5] |=> !input_buffer_en)
		else $error("Buffer enabled while its pin is low.");
	a_cal_done: assert property ($past(cal_kind) != 3'h0 && cal_kind == 3'h0 |->
		##[0:2] !result_valid_n)
		else $error("Result flag not low at calibration end.");
	a_cal_hold: assert property ($changed(cal_kind) && $past(cal_kind) == 3'h0 |=>
		$stable(cal_kind) [*8])
		else $error("Calibration kind changed right after start.");
	a_discard_fast: assert property (result_discard |-> filter_active == 2'h1)
		else $error("Discarded result outside fast filter.");
	cover property (temp_diode_en);
	cover property ($past(cal_kind) == 3'h3 && cal_kind == 3'h0);
	cover property ($fell(result_discard));
endmodule

bind acc_ctrl acc_ctrl_props #(.MOD_CYCLES_PER_CONV(MOD_CYCLES_PER_CONV)) u_acc_ctrl_props (
	.core_clk, .reset_n, .buffer_pin, .result_valid_n, .ain_pos_en, .ain_neg_en,
	.common_pos_en, .common_neg_en, .temp_diode_en, .burnout_source_en, .burnout_sink_en,
	.input_buffer_en, .gain_factor, .filter_active, .result_discard, .cal_kind
);

// ===== acc_pkg.sv
// Package with register map, field layout, reset values and timing for the converter control.
package acc_pkg;
	// Register byte addresses on the 32-bit bus.
	localparam logic [7:0] ADDR_SETUP   = 8'h00;
	localparam logic [7:0] ADDR_MUX     = 8'h04;
	localparam logic [7:0] ADDR_ANALOG  = 8'h08;
	localparam logic [7:0] ADDR_EXC_ONE = 8'h0C;
	localparam logic [7:0] ADDR_EXC_TWO = 8'h10;
	localparam logic [7:0] ADDR_OFFSET  = 8'h14;
	localparam logic [7:0] ADDR_IO_LVL  = 8'h18;
	localparam logic [7:0] ADDR_IO_DIR  = 8'h1C;
	localparam logic [7:0] ADDR_CAL_CMD = 8'h20;
	localparam logic [7:0] ADDR_FILTER  = 8'h24;
	localparam logic [7:0] ADDR_STATUS  = 8'h28;

	// Reset values.
	localparam logic [7:0] SETUP_RST    = 8'h0E;
	localparam logic [7:0] MUX_RST      = 8'h01;
	localparam logic [7:0] ANALOG_RST   = 8'h00;
	localparam logic [7:0] IO_DIR_RST   = 8'hFF;
	localparam logic [7:0] ZERO_RST     = 8'h00;

	// Setup register fields.
	localparam int SETUP_SPEED_BIT  = 4;
	localparam int SETUP_REF_EN_BIT = 3;
	localparam int SETUP_REF_HI_BIT = 2;
	localparam int SETUP_BUF_EN_BIT = 1;
	// Analog control fields.
	localparam int ANALOG_BURNOUT_BIT = 7;
	localparam int ANALOG_R2_LSB      = 5;
	localparam int ANALOG_R1_LSB      = 3;
	// Mux selects.
	localparam logic [3:0] SEL_TEMP_DIODE = 4'hF;
	// Status fields.
	localparam int STAT_BUSY_BIT   = 0;
	localparam int STAT_READY_BIT  = 1;
	localparam int STAT_FILT_LSB   = 2;
	localparam int STAT_DISC_BIT   = 4;

	// Modulator clock division.
	localparam logic [7:0] MOD_DIV_SLOW_LAST = 8'hFF;
	localparam logic [7:0] MOD_DIV_FAST_LAST = 8'h7F;
	// Calibration lengths in conversion periods.
	localparam logic [3:0] CAL_SINGLE_PERIODS = 4'h7;
	localparam logic [3:0] CAL_DOUBLE_PERIODS = 4'hE;
	// Auto filter stage where the sequence rests.
	localparam logic [1:0] AUTO_LAST_STAGE = 2'h3;

	typedef enum logic [2:0] {
		ACC_CAL_NONE, ACC_CAL_SELF_OFS, ACC_CAL_SELF_GAIN, ACC_CAL_SELF_BOTH,
		ACC_CAL_SYS_OFS, ACC_CAL_SYS_GAIN
	} acc_cal_e;

	typedef enum logic [1:0] {
		ACC_FILT_AUTO, ACC_FILT_FAST, ACC_FILT_SINC2, ACC_FILT_SINC3
	} acc_filt_e;

	typedef enum logic [0:0] {ACC_ST_IDLE, ACC_ST_CAL} acc_state_e;
endpackage

// ===== tb.sv
// Self-checking testbench for the converter control block.
`timescale 1ns/100ps
module tb;
	import acc_pkg::*;
	typedef struct packed {
		logic [7:0] mux;
		logic [7:0] ana;
		logic [7:0] pos;
		logic [7:0] neg;
		logic [2:0] cct;
	} acc_row_s;
	logic        core_clk = 1'b0;
	logic        reset_n = 1'b0;
	logic [7:0]  avs_address = 8'h00;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic        buffer_pin = 1'b0;
	logic [7:0]  io_in = 8'h3C;
	logic [31:0] avs_readdata, rd;
	logic        avs_waitrequest, mod_clk_out, result_valid_n, common_pos_en, common_neg_en;
	logic        temp_diode_en, burnout_source_en, burnout_sink_en, input_buffer_en;
	logic        offset_negative, ref_internal_en, ref_high, result_discard;
	logic [7:0]  io_out, io_oe_n, ain_pos_en, ain_neg_en, gain_factor;
	logic [10:0] excitation_one_scaled, excitation_two_scaled;
	logic [6:0]  offset_magnitude;
	logic [1:0]  filter_active;
	logic [2:0]  cal_kind;
	logic [2:0]  got [4];
	int          errors = 0, compares = 0, n, ns, len;
	acc_row_s    rows [8] = '{
		'{8'h00, 8'h00, 8'h01, 8'h01, 3'b000}, '{8'h17, 8'h81, 8'h02, 8'h80, 3'b000},
		'{8'h7E, 8'h02, 8'h80, 8'h00, 3'b010}, '{8'h96, 8'h83, 8'h00, 8'h40, 3'b100},
		'{8'hFF, 8'h04, 8'h00, 8'h00, 3'b001}, '{8'hE8, 8'h85, 8'h00, 8'h00, 3'b110},
		'{8'h35, 8'h06, 8'h08, 8'h20, 3'b000}, '{8'h52, 8'h87, 8'h20, 8'h04, 3'b000}};

	acc_ctrl #(.MOD_CYCLES_PER_CONV(16'h0002)) u_acc_ctrl (
		.core_clk, .reset_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_readdata, .avs_waitrequest, .buffer_pin, .io_in, .io_out, .io_oe_n,
		.mod_clk_out, .result_valid_n, .ain_pos_en, .ain_neg_en, .common_pos_en,
		.common_neg_en, .temp_diode_en, .burnout_source_en, .burnout_sink_en,
		.input_buffer_en, .excitation_one_scaled, .excitation_two_scaled, .gain_factor,
		.offset_negative, .offset_magnitude, .ref_internal_en, .ref_high, .filter_active,
		.result_discard, .cal_kind);

	always #2.5 core_clk = ~core_clk;

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic give_verdict();
		if (errors == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic tick(input int c);
		repeat (c) @(posedge core_clk);
	endtask

	// One Avalon transfer; the request stands until waitrequest is sampled low.
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge core_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		k = 0;
		do begin
			@(posedge core_clk);
			k++;
		end while (avs_waitrequest !== 1'b0 && k < 40);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		if (k >= 40) begin
			errors++;
			give_verdict();
		end
	endtask

	// Syncs to a rising edge twice, then counts one full period.
	task automatic mod_period(input logic [8:0] exp);
		int k;
		for (int e = 0; e < 3; e++) begin
			k = 0;
			while (mod_clk_out !== 1'b0 && k < 600) begin
				@(posedge core_clk);
				k++;
			end
			while (mod_clk_out !== 1'b1 && k < 600) begin
				@(posedge core_clk);
				k++;
			end
		end
		chk(k, exp);
	endtask

	initial begin
		tick(16);
		reset_n <= 1'b1;
		tick(2);
		chk(io_oe_n, IO_DIR_RST);
		chk({ref_internal_en, ref_high}, 2'b11);
		bus(0, ADDR_SETUP, 0);
		chk(rd, SETUP_RST);
		bus(0, ADDR_IO_DIR, 0);
		chk(rd, IO_DIR_RST);
		bus(0, 8'h3C, 0);
		chk(rd, 0);
		foreach (rows[i]) begin
			bus(1, ADDR_MUX, rows[i].mux);
			bus(1, ADDR_ANALOG, rows[i].ana);
			tick(3);
			chk(ain_pos_en, rows[i].pos);
			chk(ain_neg_en, rows[i].neg);
			chk({common_pos_en, common_neg_en, temp_diode_en}, rows[i].cct);
			chk(gain_factor, 8'h01 << rows[i].ana[2:0]);
			chk({burnout_source_en, burnout_sink_en}, {2{rows[i].ana[7]}});
		end
		bus(1, ADDR_EXC_ONE, 8'hC3);
		bus(1, ADDR_EXC_TWO, 8'h5A);
		for (int r = 0; r < 4; r++) begin
			bus(1, ADDR_ANALOG, {1'b0, r[1:0], r[1:0], 3'b000});
			tick(3);
			chk(excitation_one_scaled, (r == 0) ? 11'h000 : 11'h0C3 << (r - 1));
			chk(excitation_two_scaled, (r == 0) ? 11'h000 : 11'h05A << (r - 1));
		end
		bus(1, ADDR_IO_DIR, 8'h0F);
		bus(1, ADDR_IO_LVL, 8'hA5);
		tick(3);
		chk(io_oe_n, 8'h0F);
		chk(io_out[7:4], 4'hA);
		bus(0, ADDR_IO_LVL, 0);
		chk(rd, 8'hAC);
		buffer_pin <= 1'b1;
		bus(1, ADDR_SETUP, 8'h10);
		tick(5);
		chk({input_buffer_en, ref_internal_en, ref_high}, 3'b000);
		bus(1, ADDR_SETUP, 8'h16);
		tick(5);
		chk({input_buffer_en, ref_internal_en, ref_high}, 3'b101);
		buffer_pin <= 1'b0;
		tick(5);
		chk(input_buffer_en, 0);
		mod_period(9'd256);
		bus(1, ADDR_SETUP, SETUP_RST);
		mod_period(9'd128);
		for (int m = 3; m >= 0; m--) begin
			bus(1, ADDR_FILTER, m);
			bus(0, ADDR_FILTER, 0);
			chk(rd, m);
			tick(3);
			if (m != 0) chk(filter_active, m);
		end
		bus(1, ADDR_MUX, 8'h23);
		tick(3);
		got[0] = {filter_active, result_discard};
		ns = 1;
		n = 0;
		while (ns < 4 && n < 3000) begin
			@(posedge core_clk);
			n++;
			if ({filter_active, result_discard} !== got[ns - 1]) begin
				got[ns] = {filter_active, result_discard};
				ns++;
			end
		end
		chk({got[0], got[1], got[2], got[3]}, 12'b011_010_100_110);
		bus(1, ADDR_ANALOG, 8'h03);
		for (int c = 1; c < 6; c++) begin
			len = ((c == 3) ? 14 : 7) * 256;
			bus(1, ADDR_CAL_CMD, c);
			bus(0, ADDR_CAL_CMD, 0);
			chk(rd, c);
			chk(cal_kind, c);
			bus(1, ADDR_CAL_CMD, 6 - c);
			bus(0, ADDR_CAL_CMD, 0);
			chk(rd, c);
			chk(result_valid_n, 1);
			n = 0;
			while (result_valid_n !== 1'b0 && n < 8000) begin
				@(posedge core_clk);
				n++;
			end
			chk(n > len - 40 && n < len + 8, 1);
			bus(0, ADDR_CAL_CMD, 0);
			chk(rd, 0);
		end
		bus(1, ADDR_CAL_CMD, 6);
		bus(0, ADDR_CAL_CMD, 0);
		chk(rd, 0);
		bus(1, ADDR_OFFSET, 8'hC5);
		bus(0, ADDR_OFFSET, 0);
		chk(rd, 8'hC5);
		tick(3);
		chk({offset_negative, offset_magnitude}, 8'hC5);
		reset_n <= 1'b0;
		tick(2);
		reset_n <= 1'b1;
		tick(2);
		chk({io_oe_n, offset_negative, offset_magnitude}, {IO_DIR_RST, 8'h00});
		chk({result_valid_n, filter_active, result_discard}, 4'b1011);
		bus(0, ADDR_SETUP, 0);
		chk(rd, SETUP_RST);
		give_verdict();
	end
endmodule
